// [aicr_top.sv]
// AXI4-Lite register bank for the audio input path configuration
//
// How it works
// - Bit 0 of fifo_mode_select: 0 automatic FIFO, 1 software-fed manual.
// - Four write-only byte registers form the manual word, lowest address bits 7:0.
// - Audio config bit 4 swaps left and right input channels.
// - Audio config bit 3 skips the ADC trim with multiplier and offset.
// - Filter bypass bits 3:0 adjust the high-pass filter output.
// - Filter bypass bit 4 routes samples around the high-pass filter.
// - Filter bypass bit 5 skips the automatic level control.
// - Filter bypass bit 6 bypasses the low-pass filter.
// - Filter bypass bit 7 adds a factor-two decimation.
// - Gain register bit 7 selects automatic level control per channel.
// - In manual mode bits 5:0 give the channel digital gain.
// - In automatic mode bits 6:0 are the channel minimum gain.
// - In automatic mode the shared register caps gain at seven bits.
// - High volume target: bits 6:1 integer dB, bit 0 fraction.
`timescale 1ns/1ps
`include "aicr_cfg.svh"
module aicr_top
   import aicr_pkg::*;
#(
   parameter int ADDR_W = 14
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output aicr_path_t path_cfg,
   output aicr_gain_t gain_left,
   output aicr_gain_t gain_right,
   output logic [31:0] fifo_word,
   output logic fifo_push
);
   // Index decoding needs all twelve index bits plus the byte lane bits
   // A narrower address bus is refused at elaboration rather than left to alias registers
   if (ADDR_W < 14)
   begin
      $error("ADDR_W must be at least 14");
   end

   // Bus response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Word index from a byte address
   function automatic logic [11:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[13:2];
   endfunction

   // Stored register images; each register holds one byte
   logic [7:0] fifo_mode_r;
   logic [7:0] aud_cfg_r;
   logic [7:0] cal_mul_r;
   logic [7:0] cal_ofs_r;
   logic [7:0] filt_r;
   logic [7:0] gain_l_r;
   logic [7:0] gain_r_r;
   logic [7:0] max_gain_r;
   logic [7:0] hv_tgt_r;

   // Write channel capture: address and data may arrive in either order
   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   aicr_wstate_t wstate_r;

   assign s_axi_awready = !aw_have_r && (wstate_r == AICR_W_IDLE);
   assign s_axi_wready = !w_have_r && (wstate_r == AICR_W_IDLE);
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;

   // Current address and data, whether just taken or held
   wire [ADDR_W-1:0] wa_cur = aw_have_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wd_cur = w_have_r ? w_data_r : s_axi_wdata;
   wire [3:0] ws_cur = w_have_r ? w_strb_r : s_axi_wstrb;
   wire aw_ok = aw_have_r || aw_fire;
   wire w_ok = w_have_r || w_fire;
   wire do_write = aw_ok && w_ok && (wstate_r == AICR_W_IDLE);
   wire [11:0] widx = word_idx(wa_cur);
   // Only byte lane 0 carries register data; other lanes are ignored
   wire lane0 = ws_cur[0];
   wire [7:0] wbyte = wd_cur[7:0];

   // Write decode
   wire hit_fifo_mode = widx == `AICR_IDX_FIFO_MODE;
   wire hit_man_b0 = widx == `AICR_IDX_MAN_B0;
   wire hit_man_b1 = widx == `AICR_IDX_MAN_B1;
   wire hit_man_b2 = widx == `AICR_IDX_MAN_B2;
   wire hit_man_b3 = widx == `AICR_IDX_MAN_B3;
   wire hit_aud_cfg = widx == `AICR_IDX_AUD_CFG;
   wire hit_cal_mul = widx == `AICR_IDX_CAL_MUL;
   wire hit_cal_ofs = widx == `AICR_IDX_CAL_OFS;
   wire hit_filt = widx == `AICR_IDX_FILT;
   wire hit_gain_l = widx == `AICR_IDX_GAIN_L;
   wire hit_gain_r = widx == `AICR_IDX_GAIN_R;
   wire hit_max_gain = widx == `AICR_IDX_MAX_GAIN;
   wire hit_hv_tgt = widx == `AICR_IDX_HV_TGT;
   wire hit_man = hit_man_b0 | hit_man_b1 | hit_man_b2 | hit_man_b3;
   wire w_mapped = hit_fifo_mode | hit_man | hit_aud_cfg | hit_cal_mul | hit_cal_ofs |
                   hit_filt | hit_gain_l | hit_gain_r | hit_max_gain | hit_hv_tgt;
   // A write to a mapped register without lane 0 still completes with OKAY but stores nothing
   wire wr_en = do_write && lane0;

   // Write handshake and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         wstate_r <= AICR_W_IDLE;
      end
      else
      begin
         unique case (wstate_r)
            AICR_W_IDLE:
            begin
               if (aw_fire)
                  aw_addr_r <= s_axi_awaddr;
               if (w_fire)
               begin
                  w_data_r <= s_axi_wdata;
                  w_strb_r <= s_axi_wstrb;
               end
               if (do_write)
               begin
                  aw_have_r <= 1'b0;
                  w_have_r <= 1'b0;
                  bvalid_r <= 1'b1;
                  bresp_r <= w_mapped ? RESP_OKAY : RESP_SLVERR;
                  wstate_r <= AICR_W_RESP;
               end
               else
               begin
                  aw_have_r <= aw_ok;
                  w_have_r <= w_ok;
               end
            end
            AICR_W_RESP:
            begin
               if (s_axi_bready)
               begin
                  bvalid_r <= 1'b0;
                  wstate_r <= AICR_W_IDLE;
               end
            end
            // Unused state codes fall back to idle with no response pending
            default:
            begin
               bvalid_r <= 1'b0;
               wstate_r <= AICR_W_IDLE;
            end
         endcase
      end
   end
   // Response straight from flops, so it cannot glitch while the master waits
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Register storage; reserved upper bits of narrow fields are kept as written
   // Manual byte indices have no storage here; the collector keeps them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fifo_mode_r <= `AICR_RST_FIFO_MODE;
         aud_cfg_r <= `AICR_RST_AUD_CFG;
         cal_mul_r <= `AICR_RST_CAL;
         cal_ofs_r <= `AICR_RST_CAL;
         filt_r <= `AICR_RST_FILT;
         gain_l_r <= `AICR_RST_GAIN;
         gain_r_r <= `AICR_RST_GAIN;
         max_gain_r <= `AICR_RST_MAX_GAIN;
         hv_tgt_r <= `AICR_RST_HV_TGT;
      end
      else if (wr_en)
      begin
         if (hit_fifo_mode)
            fifo_mode_r <= wbyte;
         if (hit_aud_cfg)
            aud_cfg_r <= wbyte;
         if (hit_cal_mul)
            cal_mul_r <= wbyte;
         if (hit_cal_ofs)
            cal_ofs_r <= wbyte;
         if (hit_filt)
            filt_r <= wbyte;
         if (hit_gain_l)
            gain_l_r <= wbyte;
         if (hit_gain_r)
            gain_r_r <= wbyte;
         if (hit_max_gain)
            max_gain_r <= wbyte;
         if (hit_hv_tgt)
            hv_tgt_r <= wbyte;
      end
   end

   wire man_mode = fifo_mode_r[`AICR_FIFO_MAN_BIT];
   wire [3:0] man_we = {4{wr_en}} & {hit_man_b3, hit_man_b2, hit_man_b1, hit_man_b0};
   // Collection state, mirrored in the status register for software
   logic [2:0] man_pending;

   aicr_word_asm u_word_asm (
      .aclk(aclk),
      .aresetn(aresetn),
      .manual_en(man_mode),
      .byte_we(man_we),
      .byte_data(wbyte),
      .word_data(fifo_word),
      .word_push(fifo_push),
      .pending(man_pending)
   );

   // Path controls out to the datapath
   always_comb
   begin
      path_cfg.fifo_manual = man_mode;
      path_cfg.swap_lr = aud_cfg_r[`AICR_CFG_SWAP_BIT];
      path_cfg.trim_bypass = aud_cfg_r[`AICR_CFG_TRIM_BYP_BIT];
      path_cfg.cal_mul = cal_mul_r;
      path_cfg.cal_offset = cal_ofs_r;
      path_cfg.hpf_adjust = filt_r[3:0];
      path_cfg.hpf_bypass = filt_r[`AICR_FILT_HPF_BYP_BIT];
      path_cfg.alc_bypass = filt_r[`AICR_FILT_ALC_BYP_BIT];
      path_cfg.lpf_bypass = filt_r[`AICR_FILT_LPF_BYP_BIT];
      path_cfg.double_decim = filt_r[`AICR_FILT_DDS_BIT];
      path_cfg.max_gain = max_gain_r[6:0];
      path_cfg.hv_target_int = hv_tgt_r[6:1];
      path_cfg.hv_target_frac = hv_tgt_r[0];
   end

   // Per-channel gain fields; both views, bits 5:0 and bits 6:0, are offered, mode picks the user
   always_comb
   begin
      gain_left.auto_mode = gain_l_r[`AICR_GAIN_AUTO_BIT];
      gain_right.auto_mode = gain_r_r[`AICR_GAIN_AUTO_BIT];
      gain_left.manual_gain = gain_l_r[5:0];
      gain_right.manual_gain = gain_r_r[5:0];
      gain_left.min_gain = gain_l_r[6:0];
      gain_right.min_gain = gain_r_r[6:0];
   end

   // Read channel: byte registers read back, manual bytes read as zero
   // Reads and writes run side by side and share no handshake state
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   // No new address while an answer waits, so rdata cannot move under a slow master
   assign s_axi_arready = !rvalid_r;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [11:0] ridx = word_idx(s_axi_araddr);
   logic [7:0] rbyte;
   logic r_mapped;
   always_comb
   begin
      rbyte = 8'h00;
      r_mapped = 1'b1;
      unique case (ridx)
         `AICR_IDX_FIFO_MODE: rbyte = fifo_mode_r;
         `AICR_IDX_MAN_B0, `AICR_IDX_MAN_B1, `AICR_IDX_MAN_B2, `AICR_IDX_MAN_B3: rbyte = 8'h00;
         `AICR_IDX_AUD_CFG: rbyte = aud_cfg_r;
         `AICR_IDX_CAL_MUL: rbyte = cal_mul_r;
         `AICR_IDX_CAL_OFS: rbyte = cal_ofs_r;
         `AICR_IDX_FILT: rbyte = filt_r;
         `AICR_IDX_GAIN_L: rbyte = gain_l_r;
         `AICR_IDX_GAIN_R: rbyte = gain_r_r;
         `AICR_IDX_MAX_GAIN: rbyte = max_gain_r;
         `AICR_IDX_HV_TGT: rbyte = hv_tgt_r;
         // Shows which lower manual bytes are collected
         `AICR_IDX_STATUS: rbyte = {5'h00, man_pending};
         default: r_mapped = 1'b0;
      endcase
   end

   // Read answer held until taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rbyte};
         rresp_r <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end
   // Read outputs come straight from the answer flops
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
endmodule

// [aicr_cfg.svh]
// Register offsets, field positions, reset values and timing for the audio input config bank
`ifndef AICR_CFG_SVH
`define AICR_CFG_SVH
// Printed offsets are not all word multiples, so they are indices; byte address is index*4
`define AICR_IDX_FIFO_MODE 12'hB2C
`define AICR_IDX_MAN_B0 12'hB30
`define AICR_IDX_MAN_B1 12'hB31
`define AICR_IDX_MAN_B2 12'hB32
`define AICR_IDX_MAN_B3 12'hB33
`define AICR_IDX_AUD_CFG 12'hB35
`define AICR_IDX_CAL_MUL 12'hB36
`define AICR_IDX_CAL_OFS 12'hB37
`define AICR_IDX_FILT 12'hB40
`define AICR_IDX_GAIN_L 12'hB41
`define AICR_IDX_GAIN_R 12'hB42
`define AICR_IDX_MAX_GAIN 12'hB43
`define AICR_IDX_HV_TGT 12'hB44
`define AICR_IDX_STATUS 12'hB48
// Reset values
`define AICR_RST_FIFO_MODE 8'h00
`define AICR_RST_MAN 8'h00
`define AICR_RST_AUD_CFG 8'h09
`define AICR_RST_CAL 8'h00
`define AICR_RST_FILT 8'hFB
`define AICR_RST_GAIN 8'h20
`define AICR_RST_MAX_GAIN 8'h33
`define AICR_RST_HV_TGT 8'h60
// Field positions
`define AICR_FIFO_MAN_BIT 0
`define AICR_CFG_TRIM_BYP_BIT 3
`define AICR_CFG_SWAP_BIT 4
`define AICR_FILT_HPF_BYP_BIT 4
`define AICR_FILT_ALC_BYP_BIT 5
`define AICR_FILT_LPF_BYP_BIT 6
`define AICR_FILT_DDS_BIT 7
`define AICR_GAIN_AUTO_BIT 7
// Slave answers one cycle after taking a request
`define AICR_RESP_CYCLES 1
`endif

// [aicr_pkg.sv]
// Types shared by the audio input config bank
package aicr_pkg;
   // Per-channel gain settings as seen by the level control
   typedef struct packed {
      logic auto_mode;
      logic [5:0] manual_gain;
      logic [6:0] min_gain;
   } aicr_gain_t;
   // Path controls handed to the datapath
   typedef struct packed {
      logic fifo_manual;
      logic swap_lr;
      logic trim_bypass;
      logic [7:0] cal_mul;
      logic [7:0] cal_offset;
      logic [3:0] hpf_adjust;
      logic hpf_bypass;
      logic alc_bypass;
      logic lpf_bypass;
      logic double_decim;
      logic [6:0] max_gain;
      logic [5:0] hv_target_int;
      logic hv_target_frac;
   } aicr_path_t;
   // Write side state of the bus slave
   typedef enum logic [1:0] {
      AICR_W_IDLE = 2'b00,
      AICR_W_RESP = 2'b01
   } aicr_wstate_t;
endpackage

// [aicr_word_asm.sv]
// Assembles four byte writes into one manual FIFO word and pushes it
`timescale 1ns/1ps
module aicr_word_asm
   import aicr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic manual_en,
   input wire logic [3:0] byte_we,
   input wire logic [7:0] byte_data,
   output logic [31:0] word_data,
   output logic word_push,
   output logic [2:0] pending
);
   logic [31:0] word_r;
   logic [2:0] seen_r;
   logic push_r;
   wire lanes_full = &seen_r;
   wire push_nxt = manual_en && byte_we[3] && lanes_full;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         word_r <= 32'h0000_0000;
         seen_r <= 3'h0;
         push_r <= 1'b0;
      end
      else
      begin
         push_r <= push_nxt;
         for (int i = 0; i < 4; i++)
            if (byte_we[i] && manual_en)
               word_r[i*8 +: 8] <= byte_data;
         // A top byte write restarts collection, pushed or not
         if (!manual_en || byte_we[3])
            seen_r <= 3'h0;
         else
            seen_r <= seen_r | byte_we[2:0];
      end
   end
   assign word_data = word_r;
   assign word_push = push_r;
   assign pending = seen_r;
endmodule

// [aicr_top_assertions.sv]
// Concurrent checks on the audio input config bank ports
`timescale 1ns/1ps
module aicr_top_assertions
   import aicr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire aicr_path_t path_cfg,
   input wire aicr_gain_t gain_left,
   input wire logic fifo_push
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Bus answers and holding
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken during response");
   // Manual word push is a lone pulse beside its response
   a_push_pulse: assert property (fifo_push |=> !fifo_push)
      else $error("push longer than one cycle");
   a_push_manual: assert property (fifo_push |-> s_axi_bvalid && path_cfg.fifo_manual)
      else $error("push outside manual mode");
   // Settings move only when a write completes, never on their own
   a_cfg_on_write: assert property (!$stable(path_cfg) |-> $rose(s_axi_bvalid))
      else $error("path settings changed without write");
   a_gain_on_write: assert property (!$stable(gain_left) |-> $rose(s_axi_bvalid))
      else $error("gain settings changed without write");
endmodule

// [aicr_top_bench.sv]
// Self-checking bench for the audio input config bank
`timescale 1ns/1ps
module aicr_top_bench
   import aicr_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fifo_push, pushed;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, fifo_word, pword;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   aicr_path_t path_cfg;
   aicr_gain_t gain_left, gain_right;
   int fails, n_tests;
   // Protection tied off: the bank ignores it
   aicr_top #(.ADDR_W(14)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .path_cfg(path_cfg),
      .gain_left(gain_left), .gain_right(gain_right), .fifo_word(fifo_word), .fifo_push(fifo_push));
   // Compare and count
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %0h seen %0h", n, e, g);
      end
   endtask
   // Write one register; readies are sampled mid-cycle, so no edge race
   task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er);
      logic a, w, ta, tw, ok;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      a = 1'b0;
      w = 1'b0;
      while (!(a && w))
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         a = a || ta;
         w = w || tw;
      end
      @(negedge aclk);
      pushed = fifo_push;
      pword = fifo_word;
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ok = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end
      while (!ok);
      s_axi_bready <= 1'b0;
      chk("bresp", er, r);
   endtask
   // Read one register; rready comes a cycle late to exercise holding
   task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er);
      logic ok;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(negedge aclk);
         ok = s_axi_arready;
         @(posedge aclk);
      end
      while (!ok);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ok = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end
      while (!ok);
      s_axi_rready <= 1'b0;
      chk("rdata", {24'h0, e}, d);
      chk("rresp", er, r);
   endtask
   task automatic wword(input logic [31:0] v);
      wr(12'hB30, v[7:0], 2'b00);
      wr(12'hB31, v[15:8], 2'b00);
      wr(12'hB32, v[23:16], 2'b00);
      wr(12'hB33, v[31:24], 2'b00);
   endtask
   // Reset values, read-back, write-only and unmapped places
   task automatic t_regs;
      logic [11:0] ix [9];
      logic [7:0] rv [9];
      ix = '{12'hB2C, 12'hB35, 12'hB36, 12'hB37, 12'hB40, 12'hB41, 12'hB42, 12'hB43, 12'hB44};
      rv = '{8'h00, 8'h09, 8'h00, 8'h00, 8'hFB, 8'h20, 8'h20, 8'h33, 8'h60};
      chk("path_rst", {7'h0, 3'b001, 16'h0, 8'hBF, 7'h33, 6'h30, 1'b0}, {7'h0, path_cfg});
      for (int k = 0; k < 9; k++)
      begin
         rd(ix[k], rv[k], 2'b00);
         wr(ix[k], 8'hA5 ^ k[7:0], 2'b00);
         rd(ix[k], 8'hA5 ^ k[7:0], 2'b00);
      end
      rd(12'hB30, 8'h00, 2'b00);
      rd(12'hB2D, 8'h00, 2'b10);
      wr(12'hB2D, 8'hFF, 2'b10);
   endtask
   // Each field except fifo_manual and the calibration bytes reaches its datapath control, both polarities
   task automatic t_path;
      logic [7:0] v;
      wr(12'hB35, 8'h18, 2'b00);
      chk("swap_trim", 2'b11, {path_cfg.swap_lr, path_cfg.trim_bypass});
      wr(12'hB35, 8'h00, 2'b00);
      chk("swap_trim", 2'b00, {path_cfg.swap_lr, path_cfg.trim_bypass});
      for (int k = 0; k < 2; k++)
      begin
         v = k ? 8'h5A : 8'hA5;
         wr(12'hB40, v, 2'b00);
         chk("filt", v, {path_cfg.double_decim, path_cfg.lpf_bypass, path_cfg.alc_bypass,
            path_cfg.hpf_bypass, path_cfg.hpf_adjust});
         wr(12'hB43, v, 2'b00);
         chk("max_gain", v[6:0], path_cfg.max_gain);
         wr(12'hB44, v, 2'b00);
         chk("hv_tgt", v[6:0], {path_cfg.hv_target_int, path_cfg.hv_target_frac});
         wr(12'hB41, v, 2'b00);
         wr(12'hB42, ~v, 2'b00);
         chk("gain_l", {v[7], v[5:0], v[6:0]}, gain_left);
         chk("gain_r", {~v[7], ~v[5:0], ~v[6:0]}, gain_right);
      end
      // Lane 0 off: the write completes OKAY and stores nothing
      s_axi_wstrb <= 4'hE;
      wr(12'hB43, 8'h00, 2'b00);
      s_axi_wstrb <= 4'h1;
      chk("max_gain_nostrb", 7'h5A, path_cfg.max_gain);
   endtask
   // Manual word assembly: auto mode, shuffled bytes, early top byte, back to back
   task automatic t_fifo;
      wr(12'hB2C, 8'h00, 2'b00);
      wword(32'h44332211);
      chk("push_auto", 1'b0, pushed);
      wr(12'hB2C, 8'h01, 2'b00);
      wr(12'hB32, 8'h33, 2'b00);
      wr(12'hB30, 8'h11, 2'b00);
      wr(12'hB31, 8'h22, 2'b00);
      // Status shows all three lower bytes collected
      rd(12'hB48, 8'h07, 2'b00);
      wr(12'hB33, 8'h44, 2'b00);
      chk("push", 1'b1, pushed);
      chk("word", 32'h44332211, pword);
      wr(12'hB33, 8'h55, 2'b00);
      chk("push_early", 1'b0, pushed);
      wword(32'hD4C3B2A1);
      chk("push", 1'b1, pushed);
      chk("word", 32'hD4C3B2A1, pword);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // 25 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // About 60 bus operations of under 8 cycles, under 480 cycles; allow over sixty times that
   initial
   begin
      #1300000;
      fails++;
      wrap_up;
   end
   // Main sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
      s_axi_wstrb = 4'h1;
      fails = 0;
      n_tests = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_path;
      t_fifo;
      wrap_up;
   end
endmodule
bind aicr_top aicr_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .path_cfg(path_cfg), .gain_left(gain_left), .fifo_push(fifo_push));
